// File: design/lpm_ctrl.sv
`include "lpm_cfg.svh"
`default_nettype none

module lpm_ctrl #(
    parameter int          IRQ_N     = 8,
    parameter int          TB_SRC_N  = 8,
    parameter int unsigned WU_FAST_0 = `LPM_WU_FAST_0_US * `LPM_CLK_MHZ,
    parameter int unsigned WU_FAST_1 = `LPM_WU_FAST_1_US * `LPM_CLK_MHZ,
    parameter int unsigned WU_FAST_2 = `LPM_WU_FAST_2_US * `LPM_CLK_MHZ,
    parameter int unsigned WU_FAST_3 = `LPM_WU_FAST_3_US * `LPM_CLK_MHZ,
    parameter int unsigned WU_SLOW_0 = `LPM_WU_SLOW_0_US * `LPM_CLK_MHZ,
    parameter int unsigned WU_SLOW_1 = `LPM_WU_SLOW_1_US * `LPM_CLK_MHZ,
    parameter int unsigned WU_SLOW_2 = `LPM_WU_SLOW_2_US * `LPM_CLK_MHZ,
    parameter int unsigned WU_SLOW_3 = `LPM_WU_SLOW_3_US * `LPM_CLK_MHZ
) (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_arst_n,
    // wishbone slave
    input  wire logic                i_wb_cyc,
    input  wire logic                i_wb_stb,
    input  wire logic                i_wb_we,
    input  wire logic [7:0]          i_wb_adr,
    input  wire logic [31:0]         i_wb_dat,
    input  wire logic [3:0]          i_wb_sel,
    output logic      [31:0]         o_wb_dat,
    output logic                     o_wb_ack,
    // wake sources
    input  wire logic                i_stop_wake,
    input  wire logic [TB_SRC_N-1:0] i_tb_src,
    // cpu side
    input  wire logic [15:0]         i_instr_pc,
    input  wire logic [IRQ_N-1:0]    i_irq_latch,
    input  wire logic                i_wdt_irq,
    // clock and halt control
    output logic                     o_fast_osc_on,
    output logic                     o_slow_osc_on,
    output logic                     o_core_halt,
    output logic                     o_tg_clear,
    output logic                     o_cpu_wdt_halt,
    output logic                     o_periph_clk_gate,
    // resume signalling
    output logic                     o_resume,
    output logic                     o_irq_service,
    output logic                     o_tb_latch_set,
    output logic      [15:0]         o_resume_pc,
    output logic      [1:0]          o_run_mode
);

    localparam int TBSEL_W = (TB_SRC_N > 1) ? $clog2(TB_SRC_N) : 1;
    localparam int WU_W    = `LPM_WU_CNT_W;

    typedef struct packed {
        lpm_pkg::lpm_phase_type phase;
        logic [7:0]             sys_ctrl_one;
        logic [7:0]             sys_ctrl_two;
        logic [IRQ_N-1:0]       irq_enable_flags;
        logic [7:0]             irq_ctrl;
        logic [15:0]            resume_pc;
        logic [WU_W-1:0]        wu_cnt;
        logic [2:0]             wake_sync;
        logic [2:0]             tb_sync;
        logic                   ack;
        logic [31:0]            rdat;
        logic                   fast_on;
        logic                   slow_on;
        logic                   halt_all;
        logic                   cpu_halt;
        logic                   gate;
        logic                   resume;
        logic                   service;
        logic                   tb_set;
    } lpm_state_type;

    lpm_state_type st_q;
    lpm_state_type st_d;

    logic               stop_release_select;
    logic [1:0]         warmup_select;
    logic               master_irq_enable;
    logic               time_base_on;
    logic [TBSEL_W-1:0] time_base_clock_select;
    logic               dual_clock;
    logic               return_slow;
    logic               wake_rise;
    logic               tb_fall;
    logic               irq_wake;

    assign stop_release_select    = st_q.sys_ctrl_one[`LPM_ONE_RELSEL_BIT];
    assign warmup_select          = st_q.sys_ctrl_one[`LPM_ONE_WUT_LSB +: 2];
    assign master_irq_enable      = st_q.irq_ctrl[`LPM_IRQ_MASTER_BIT];
    assign time_base_on           = st_q.irq_ctrl[`LPM_IRQ_TB_ON_BIT];
    assign time_base_clock_select = st_q.irq_ctrl[`LPM_IRQ_TBSEL_LSB +: TBSEL_W];
    assign dual_clock             = st_q.sys_ctrl_two[`LPM_TWO_SLOW_OSC_BIT];
    assign return_slow            = st_q.sys_ctrl_two[`LPM_TWO_SYSCLK_BIT];
    assign wake_rise              = st_q.wake_sync[1] & ~st_q.wake_sync[2];
    assign tb_fall                = ~st_q.tb_sync[1] & st_q.tb_sync[2];
    assign irq_wake               = |(i_irq_latch & st_q.irq_enable_flags);

    // warm-up length less one, by return target and select
    function automatic logic [WU_W-1:0] wu_len(input logic slow, input logic [1:0] sel);
        logic [WU_W-1:0] len;
        case ({slow, sel})
            3'h0:    len = WU_W'(WU_FAST_0 - 1);
            3'h1:    len = WU_W'(WU_FAST_1 - 1);
            3'h2:    len = WU_W'(WU_FAST_2 - 1);
            3'h3:    len = WU_W'(WU_FAST_3 - 1);
            3'h4:    len = WU_W'(WU_SLOW_0 - 1);
            3'h5:    len = WU_W'(WU_SLOW_1 - 1);
            3'h6:    len = WU_W'(WU_SLOW_2 - 1);
            default: len = WU_W'(WU_SLOW_3 - 1);
        endcase
        return len;
    endfunction

    function automatic lpm_pkg::lpm_run_mode_type run_mode(input logic [7:0] two);
        lpm_pkg::lpm_run_mode_type m;
        if (!two[`LPM_TWO_SYSCLK_BIT]) begin
            m = two[`LPM_TWO_SLOW_OSC_BIT] ? lpm_pkg::lpm_dual_clock_fast_run : lpm_pkg::lpm_single_clock_run;
        end else begin
            m = two[`LPM_TWO_FAST_OSC_BIT] ? lpm_pkg::lpm_slow_run_fast_on : lpm_pkg::lpm_slow_run_fast_off;
        end
        return m;
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.wake_sync = {st_q.wake_sync[1:0], i_stop_wake};
        st_d.tb_sync   = {st_q.tb_sync[1:0], i_tb_src[time_base_clock_select]};
        st_d.resume    = 1'h0;
        st_d.service   = 1'h0;
        st_d.tb_set    = 1'h0;

        // bus slave: one-cycle answer, unmapped reads zero
        st_d.ack = 1'h0;
        if (i_wb_cyc && i_wb_stb && !st_q.ack) begin
            st_d.ack  = 1'h1;
            st_d.rdat = 32'h0000_0000;
            case (i_wb_adr)
                `LPM_ADR_SYS_CTRL_ONE: st_d.rdat[7:0] = st_q.sys_ctrl_one;
                `LPM_ADR_SYS_CTRL_TWO: st_d.rdat[7:0] = st_q.sys_ctrl_two;
                `LPM_ADR_IRQ_ENABLE:   st_d.rdat[IRQ_N-1:0] = st_q.irq_enable_flags;
                `LPM_ADR_IRQ_CTRL:     st_d.rdat[7:0] = st_q.irq_ctrl;
                `LPM_ADR_STATUS:       st_d.rdat[5:0] = {2'(run_mode(st_q.sys_ctrl_two)), 1'h0, 3'(st_q.phase)};
                `LPM_ADR_RESUME_PC:    st_d.rdat[15:0] = st_q.resume_pc;
                default:               st_d.rdat = 32'h0000_0000;
            endcase
            if (i_wb_we && i_wb_sel[0]) begin
                case (i_wb_adr)
                    `LPM_ADR_SYS_CTRL_ONE: st_d.sys_ctrl_one = i_wb_dat[7:0];
                    `LPM_ADR_SYS_CTRL_TWO: st_d.sys_ctrl_two = i_wb_dat[7:0];
                    `LPM_ADR_IRQ_ENABLE:   st_d.irq_enable_flags = i_wb_dat[IRQ_N-1:0];
                    `LPM_ADR_IRQ_CTRL:     st_d.irq_ctrl = i_wb_dat[7:0];
                    default:               st_d.ack = 1'h1;
                endcase
            end
        end

        case (st_q.phase)
            lpm_pkg::lpm_run: begin
                if (st_q.sys_ctrl_one[`LPM_ONE_STOP_BIT]) begin
                    st_d.resume_pc = i_instr_pc + `LPM_PC_ADVANCE;
                    if (stop_release_select && st_q.wake_sync[1]) begin
                        // level mode with pin already high: straight to warm-up
                        st_d.phase  = lpm_pkg::lpm_warmup;
                        st_d.wu_cnt = wu_len(return_slow, warmup_select);
                    end else begin
                        st_d.phase = lpm_pkg::lpm_stop;
                    end
                end else if (st_q.sys_ctrl_two[`LPM_TWO_CPU_HALT_BIT]) begin
                    if (i_wdt_irq) begin
                        st_d.sys_ctrl_two[`LPM_TWO_CPU_HALT_BIT] = 1'h0;
                        st_d.service = 1'h1;
                    end else begin
                        st_d.phase     = lpm_pkg::lpm_cpu_halt;
                        st_d.resume_pc = i_instr_pc + `LPM_PC_ADVANCE;
                    end
                end else if (st_q.sys_ctrl_two[`LPM_TWO_GATE_BIT]) begin
                    if (i_wdt_irq) begin
                        st_d.sys_ctrl_two[`LPM_TWO_GATE_BIT] = 1'h0;
                        st_d.service = 1'h1;
                    end else begin
                        st_d.phase     = lpm_pkg::lpm_gated_halt;
                        st_d.resume_pc = i_instr_pc + `LPM_PC_ADVANCE;
                        st_d.tb_set    = time_base_on;
                    end
                end
            end
            lpm_pkg::lpm_stop: begin
                // key wake-up inputs are not release sources here
                if (stop_release_select ? st_q.wake_sync[1] : wake_rise) begin
                    st_d.phase  = lpm_pkg::lpm_warmup;
                    st_d.wu_cnt = wu_len(return_slow, warmup_select);
                end
            end
            lpm_pkg::lpm_warmup: begin
                if (st_q.wu_cnt == '0) begin
                    st_d.phase = lpm_pkg::lpm_run;
                    st_d.sys_ctrl_one[`LPM_ONE_STOP_BIT] = 1'h0;
                    st_d.resume = 1'h1;
                end else begin
                    st_d.wu_cnt = st_q.wu_cnt - WU_W'(1);
                end
            end
            lpm_pkg::lpm_cpu_halt: begin
                if (irq_wake) begin
                    st_d.phase = lpm_pkg::lpm_run;
                    st_d.sys_ctrl_two[`LPM_TWO_CPU_HALT_BIT] = 1'h0;
                    st_d.service = master_irq_enable;
                    st_d.resume  = ~master_irq_enable;
                end
            end
            lpm_pkg::lpm_gated_halt: begin
                if (tb_fall) begin
                    st_d.phase = lpm_pkg::lpm_run;
                    st_d.sys_ctrl_two[`LPM_TWO_GATE_BIT] = 1'h0;
                    st_d.service = master_irq_enable & st_q.irq_enable_flags[`LPM_TB_IRQ_INDEX] & time_base_on;
                    st_d.resume  = ~(master_irq_enable & st_q.irq_enable_flags[`LPM_TB_IRQ_INDEX] & time_base_on);
                end
            end
            default: begin
                st_d.phase = lpm_pkg::lpm_run;
            end
        endcase

        // registered outputs follow the next phase
        st_d.halt_all = (st_d.phase == lpm_pkg::lpm_stop) || (st_d.phase == lpm_pkg::lpm_warmup);
        st_d.cpu_halt = (st_d.phase == lpm_pkg::lpm_cpu_halt);
        st_d.gate     = (st_d.phase == lpm_pkg::lpm_gated_halt);
        case (st_d.phase)
            lpm_pkg::lpm_stop: begin
                st_d.fast_on = 1'h0;
                st_d.slow_on = 1'h0;
            end
            lpm_pkg::lpm_warmup: begin
                st_d.fast_on = dual_clock ? ~return_slow : 1'h1;
                st_d.slow_on = dual_clock;
            end
            default: begin
                st_d.fast_on = st_d.sys_ctrl_two[`LPM_TWO_FAST_OSC_BIT];
                st_d.slow_on = st_d.sys_ctrl_two[`LPM_TWO_SLOW_OSC_BIT];
            end
        endcase
    end

    // reset pin restarts in single-clock fast run
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q                  <= '0;
            st_q.phase            <= lpm_pkg::lpm_run;
            st_q.sys_ctrl_one     <= `LPM_RST_SYS_CTRL_ONE;
            st_q.sys_ctrl_two     <= `LPM_RST_SYS_CTRL_TWO;
            st_q.irq_enable_flags <= '0;
            st_q.irq_ctrl         <= `LPM_RST_IRQ_CTRL;
            st_q.fast_on          <= 1'h1;
            // wake pin idles high: no false rising edge after reset
            st_q.wake_sync        <= 3'h7;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_wb_ack          = st_q.ack;
    assign o_wb_dat          = st_q.rdat;
    assign o_fast_osc_on     = st_q.fast_on;
    assign o_slow_osc_on     = st_q.slow_on;
    assign o_core_halt       = st_q.halt_all;
    assign o_tg_clear        = st_q.halt_all;
    assign o_cpu_wdt_halt    = st_q.cpu_halt;
    assign o_periph_clk_gate = st_q.gate;
    assign o_resume          = st_q.resume;
    assign o_irq_service     = st_q.service;
    assign o_tb_latch_set    = st_q.tb_set;
    assign o_resume_pc       = st_q.resume_pc;
    assign o_run_mode        = 2'(run_mode(st_q.sys_ctrl_two));

    a_stop_edge_only: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_stop) && !stop_release_select && !wake_rise |=> (st_q.phase == lpm_pkg::lpm_stop))
        else $error("stop left without a rising wake edge");

    a_stop_entry_high: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_run) && st_q.sys_ctrl_one[`LPM_ONE_STOP_BIT] && !stop_release_select
        |=> (st_q.phase == lpm_pkg::lpm_stop) && !o_fast_osc_on && !o_slow_osc_on)
        else $error("edge mode stop entry failed");

    a_osc_restart: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_warmup) |-> (o_slow_osc_on == dual_clock)
        && (o_fast_osc_on == (!dual_clock || !return_slow)))
        else $error("wrong oscillator restart set");

    a_warmup_length: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_stop) ##1 (st_q.phase == lpm_pkg::lpm_warmup)
        |-> (st_q.wu_cnt == wu_len(return_slow, warmup_select)))
        else $error("warm-up length not taken from select");

    a_warmup_resume: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_warmup) && (st_q.wu_cnt == '0)
        |=> o_resume && !o_core_halt && !st_q.sys_ctrl_one[`LPM_ONE_STOP_BIT] ##1 !o_resume)
        else $error("warm-up end did not resume");

    a_tg_cleared: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $fell(o_core_halt) |-> $past(o_tg_clear) && o_resume)
        else $error("timing generator not cleared before restart");

    a_resume_addr: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_run) && st_q.sys_ctrl_two[`LPM_TWO_CPU_HALT_BIT] && !i_wdt_irq
        && !st_q.sys_ctrl_one[`LPM_ONE_STOP_BIT] |=> o_cpu_wdt_halt && (o_resume_pc == $past(i_instr_pc) + 16'h0002))
        else $error("halt entry address wrong");

    a_halt_release: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_cpu_halt) && irq_wake
        |=> !o_cpu_wdt_halt && !st_q.sys_ctrl_two[`LPM_TWO_CPU_HALT_BIT]
        && (o_irq_service == $past(master_irq_enable)) && (o_resume != o_irq_service))
        else $error("cpu halt release wrong");

    a_wdt_blocks: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_run) && !st_q.sys_ctrl_one[`LPM_ONE_STOP_BIT]
        && (st_q.sys_ctrl_two[`LPM_TWO_CPU_HALT_BIT] || st_q.sys_ctrl_two[`LPM_TWO_GATE_BIT]) && i_wdt_irq
        |=> (st_q.phase == lpm_pkg::lpm_run) && o_irq_service)
        else $error("halt entered despite watchdog interrupt");

    a_gate_entry: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_periph_clk_gate) |-> (o_tb_latch_set == $past(time_base_on)) && !o_cpu_wdt_halt)
        else $error("time-base latch not set on gated entry");

    a_gate_release: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_gated_halt) && !tb_fall |=> o_periph_clk_gate)
        else $error("gated halt ended without time-base edge");

    a_level_release: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_stop) && stop_release_select && st_q.wake_sync[1]
        |=> (st_q.phase == lpm_pkg::lpm_warmup) && o_core_halt)
        else $error("level release did not start warm-up");

    a_warmup_halted: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_warmup) |-> o_core_halt && o_tg_clear)
        else $error("warm-up not fully halted");

    a_halt_outputs: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_cpu_halt) |-> o_cpu_wdt_halt && !o_core_halt && !o_periph_clk_gate)
        else $error("cpu halt outputs wrong");

    a_gated_clocks: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_gated_halt) |-> o_periph_clk_gate && !o_cpu_wdt_halt && !o_core_halt)
        else $error("gated halt outputs wrong");

    a_gated_release: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_gated_halt) && tb_fall
        |=> !o_periph_clk_gate && !st_q.sys_ctrl_two[`LPM_TWO_GATE_BIT] && (o_resume != o_irq_service))
        else $error("gated halt release wrong");

    a_level_entry: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q.phase == lpm_pkg::lpm_run) && st_q.sys_ctrl_one[`LPM_ONE_STOP_BIT] && stop_release_select
        && st_q.wake_sync[1] |=> (st_q.phase == lpm_pkg::lpm_warmup))
        else $error("level entry with pin high did not warm up");

endmodule

`default_nettype wire

// File: design/lpm_cfg.svh
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

// register byte offsets
`define LPM_ADR_SYS_CTRL_ONE 8'h00
`define LPM_ADR_SYS_CTRL_TWO 8'h04
`define LPM_ADR_IRQ_ENABLE   8'h08
`define LPM_ADR_IRQ_CTRL     8'h0C
`define LPM_ADR_STATUS       8'h10
`define LPM_ADR_RESUME_PC    8'h14

// sys_ctrl_one fields
`define LPM_ONE_STOP_BIT     7
`define LPM_ONE_RELSEL_BIT   6
`define LPM_ONE_WUT_LSB      4
// sys_ctrl_two fields
`define LPM_TWO_FAST_OSC_BIT 7
`define LPM_TWO_SLOW_OSC_BIT 6
`define LPM_TWO_SYSCLK_BIT   5
`define LPM_TWO_CPU_HALT_BIT 4
`define LPM_TWO_GATE_BIT     2
// irq control fields
`define LPM_IRQ_MASTER_BIT   0
`define LPM_IRQ_TB_ON_BIT    1
`define LPM_IRQ_TBSEL_LSB    4
`define LPM_TB_IRQ_INDEX     6

// reset values
`define LPM_RST_SYS_CTRL_ONE 8'h00
`define LPM_RST_SYS_CTRL_TWO 8'h80
`define LPM_RST_IRQ_ENABLE   8'h00
`define LPM_RST_IRQ_CTRL     8'h00

// resume address advance past the mode-start instruction
`define LPM_PC_ADVANCE       16'h0002

// clock in MHz and warm-up times in microseconds
`define LPM_CLK_MHZ          25
`define LPM_WU_FAST_0_US     12288
`define LPM_WU_FAST_1_US     4096
`define LPM_WU_FAST_2_US     3072
`define LPM_WU_FAST_3_US     1024
`define LPM_WU_SLOW_0_US     750000
`define LPM_WU_SLOW_1_US     250000
`define LPM_WU_SLOW_2_US     5850
`define LPM_WU_SLOW_3_US     1950
`define LPM_WU_CNT_W         25

`endif

// File: design/lpm_pkg.sv
`default_nettype none

package lpm_pkg;

    typedef enum logic [2:0] {
        lpm_run,
        lpm_stop,
        lpm_warmup,
        lpm_cpu_halt,
        lpm_gated_halt
    } lpm_phase_type;

    typedef enum logic [1:0] {
        lpm_single_clock_run,
        lpm_dual_clock_fast_run,
        lpm_slow_run_fast_off,
        lpm_slow_run_fast_on
    } lpm_run_mode_type;

endpackage

`default_nettype wire

// File: tb/lpm_wake_src.sv
`default_nettype none

module lpm_wake_src (
    // clock
    input  wire logic       i_clk,
    // commands from the bench
    input  wire logic       i_pin_req,
    input  wire logic       i_tb_run,
    // wake lines
    output logic            o_stop_wake,
    output logic      [7:0] o_tb_src
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q = 3'h0;
    // driven pin, no key wake-up lines at all
    assign o_stop_wake = i_pin_req;
    always_ff @(posedge i_clk) begin
        div_q <= i_tb_run ? div_q + 3'h1 : 3'h0;
    end
    // time-base source stands low outside a run
    assign o_tb_src = {8{div_q[2]}};
endmodule

`default_nettype wire

// File: tb/low_power_mode_controller_test.sv
`default_nettype none

module low_power_mode_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, pin = 1'b1, tb_run = 1'b0, wdt = 1'b0;
    logic [7:0]  adr = 8'h00, irq = 8'h00, tbs;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] pc = 16'h0100, rpc;
    logic        swake, fosc, sosc, halt, tgc, cwh, pcg, res, svc, tbl, ack;
    logic [1:0]  rmode;
    int          num_errors = 0, checks_done = 0, svc_cnt = 0, tbl_cnt = 0;
    logic [3:0]  sel = 4'hF;
    localparam int WU_F3 = 5;
    localparam int WU_S0 = 12;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    lpm_wake_src i_src (.i_clk(clk), .i_pin_req(pin), .i_tb_run(tb_run), .o_stop_wake(swake), .o_tb_src(tbs));

    lpm_ctrl #(.WU_FAST_3(WU_F3), .WU_SLOW_0(WU_S0)) i_dut (
        .i_clk(clk), .i_arst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_stop_wake(swake),
        .i_tb_src(tbs), .i_instr_pc(pc), .i_irq_latch(irq), .i_wdt_irq(wdt), .o_fast_osc_on(fosc),
        .o_slow_osc_on(sosc), .o_core_halt(halt), .o_tg_clear(tgc), .o_cpu_wdt_halt(cwh),
        .o_periph_clk_gate(pcg), .o_resume(res), .o_irq_service(svc), .o_tb_latch_set(tbl),
        .o_resume_pc(rpc), .o_run_mode(rmode));

    always @(posedge clk) begin
        svc_cnt += (svc === 1'b1);
        tbl_cnt += (tbl === 1'b1);
    end

    task end_sim;
        if (num_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t mismatch %h expected %h", $time, seen, exp);
        end
    endtask

    task cyc_n(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        wdat <= d;
        we <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            end_sim();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task wait_ev(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (res !== 1'b1 && svc !== 1'b1 && n < 200);
        if (n >= 200) begin
            num_errors++;
            end_sim();
        end
    endtask

    task wait_warm(input logic [1:0] osc, output int warm);
        int n;
        warm = 0;
        n = 0;
        while (res !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
            if (halt === 1'b1 && {fosc, sosc} === osc) warm++;
            if (halt === 1'b1) chk(tgc, 1'b1);
        end
        if (n >= 60) begin
            num_errors++;
            end_sim();
        end
    endtask

    task t_reset;
        wb(8'h00, 32'hB0, 1'b1);
        cyc_n(3);
        chk(halt, 1'b1);
        rst_n <= 1'b0;
        cyc_n(2);
        chk({halt, fosc, sosc, cwh, pcg, rmode}, 7'b0100000);
        rst_n <= 1'b1;
        cyc_n(1);
        wb(8'h04, 32'h0, 1'b0);
        chk(q, 32'h80);
        wb(8'h20, 32'h0, 1'b0);
        chk(q, 32'h0);
        sel <= 4'hE;
        wb(8'h08, 32'hFF, 1'b1);
        sel <= 4'hF;
        wb(8'h08, 32'h0, 1'b0);
        chk(q, 32'h0);
    endtask

    task t_stop;
        int warm;
        pc <= 16'h1230;
        wb(8'h00, 32'hB0, 1'b1);
        cyc_n(12);
        chk({halt, tgc, fosc, res}, 4'b1100);
        pin <= 1'b0;
        cyc_n(4);
        pin <= 1'b1;
        wait_warm(2'b10, warm);
        chk(warm, WU_F3);
        chk({halt, fosc, sosc, rpc}, {3'b010, 16'h1232});
        wb(8'h00, 32'h0, 1'b0);
        chk(q, 32'h30);
    endtask

    task t_halt(input logic m);
        int n, s0;
        wb(8'h0C, {31'h0, m}, 1'b1);
        wb(8'h08, 32'h01, 1'b1);
        s0 = svc_cnt;
        wb(8'h04, 32'h90, 1'b1);
        cyc_n(6);
        chk({cwh, halt, pcg}, 3'b100);
        irq <= 8'h02;
        cyc_n(6);
        chk(cwh, 1'b1);
        irq <= 8'h03;
        wait_ev(n);
        if (!m) chk(res, 1'b1);
        cyc_n(3);
        chk(svc_cnt - s0, m);
        irq <= 8'h00;
        wb(8'h04, 32'h0, 1'b0);
        chk(q, 32'h80);
        chk(cwh, 1'b0);
    endtask

    task t_level;
        int warm;
        wb(8'h04, 32'hE0, 1'b1);
        wb(8'h04, 32'h60, 1'b1);
        pin <= 1'b0;
        cyc_n(3);
        wb(8'h00, 32'hC0, 1'b1);
        cyc_n(4);
        chk({halt, fosc, sosc, res}, 4'b1000);
        pin <= 1'b1;
        wait_warm(2'b01, warm);
        chk(warm, WU_S0);
        chk({halt, fosc, sosc, rmode}, 5'b00110);
        wb(8'h00, 32'hC0, 1'b1);
        wb(8'h10, 32'h0, 1'b0);
        chk(q, 32'h22);
        wait_warm(2'b01, warm);
        wb(8'h04, 32'hE0, 1'b1);
        wb(8'h04, 32'hC0, 1'b1);
        wb(8'h04, 32'h80, 1'b1);
    endtask

    task t_wdt;
        int s0;
        s0 = svc_cnt;
        wdt <= 1'b1;
        wb(8'h04, 32'h90, 1'b1);
        cyc_n(4);
        chk(cwh, 1'b0);
        wb(8'h04, 32'h84, 1'b1);
        cyc_n(4);
        chk(pcg, 1'b0);
        chk(svc_cnt - s0, 2);
        wdt <= 1'b0;
        wb(8'h04, 32'h0, 1'b0);
        chk(q, 32'h80);
    endtask

    task t_gate;
        int n, s0, t0;
        wb(8'h0C, 32'h23, 1'b1);
        wb(8'h08, 32'h40, 1'b1);
        s0 = svc_cnt;
        t0 = tbl_cnt;
        wb(8'h04, 32'h84, 1'b1);
        cyc_n(4);
        chk({pcg, cwh, halt}, 3'b100);
        chk(tbl_cnt - t0, 1);
        tb_run <= 1'b1;
        wait_ev(n);
        cyc_n(3);
        tb_run <= 1'b0;
        chk(svc_cnt - s0, 1);
        chk(pcg, 1'b0);
        wb(8'h04, 32'h0, 1'b0);
        chk(q, 32'h80);
        wb(8'h0C, 32'h22, 1'b1);
        s0 = svc_cnt;
        wb(8'h04, 32'h84, 1'b1);
        tb_run <= 1'b1;
        wait_ev(n);
        chk(res, 1'b1);
        tb_run <= 1'b0;
        cyc_n(3);
        chk(svc_cnt - s0, 0);
    endtask

    initial begin
        cyc_n(20);
        rst_n <= 1'b1;
        cyc_n(1);
        t_reset();
        t_stop();
        t_level();
        t_halt(1'b0);
        t_halt(1'b1);
        t_wdt();
        t_gate();
        end_sim();
    end
endmodule

`default_nettype wire
